// *** hw/gpe_pkg.sv ***
// Constants shared by the event-signalling block
package gpe_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTRL_OFFS = 12'h35c;
  localparam logic [11:0] STS_OFFS = 12'h360;
  localparam logic [11:0] PIN_OFFS = 12'h364;
  localparam logic [11:0] IRQ_STS_OFFS = 12'h368;
  localparam logic [11:0] IRQ_MASK_OFFS = 12'h36c;
  localparam int INV_BIT = 0;
  localparam int P2_EN_BIT = 2;
  localparam int P3_EN_BIT = 3;
  localparam int P2_ACT_BIT = 1;
  localparam int P3_ACT_BIT = 2;
  localparam int ALT_BIT = 0;
  localparam int PIN_LVL_BIT = 1;
  localparam int REQ_INTX = 0;
  localparam int REQ_MSI = 1;
  localparam int REQ_PME = 2;
  localparam int REQ_W = 3;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam logic [31:0] STS_RESET = 32'h00000000;
  localparam logic [31:0] PIN_RESET = 32'h00000000;
  localparam logic [31:0] IRQ_STS_RESET = 32'h00000000;
  localparam logic [31:0] IRQ_MASK_RESET = 32'h00000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** hw/gpe_if.sv ***
// Control and status between register file and event router
`timescale 1ns/10ps
interface gpe_if;
  logic invert;
  logic p2_en;
  logic p3_en;
  logic alt_fn;
  logic p2_act;
  logic p3_act;
  modport regs (output invert, output p2_en, output p3_en, output alt_fn,
    input p2_act, input p3_act);
  modport route (input invert, input p2_en, input p3_en, input alt_fn,
    output p2_act, output p3_act);
endinterface

// *** hw/gpe_route.sv ***
// Per-port event diversion and shared pin drive
`timescale 1ns/10ps
module gpe_route (
  input wire logic aclk,
  input wire logic aresetn,
  gpe_if.route ev,
  input wire logic [gpe_pkg::REQ_W-1:0] p2_req,
  input wire logic [gpe_pkg::REQ_W-1:0] p3_req,
  output logic [gpe_pkg::REQ_W-1:0] p2_fwd,
  output logic [gpe_pkg::REQ_W-1:0] p3_fwd,
  input wire logic gpio_o,
  input wire logic gpio_oe,
  output logic pin_o,
  output logic pin_oe
);
  typedef struct packed {
    logic p2_act;
    logic p3_act;
    logic [gpe_pkg::REQ_W-1:0] p2_fwd;
    logic [gpe_pkg::REQ_W-1:0] p3_fwd;
    logic pin_o;
    logic pin_oe;
  } route_state_t;
  route_state_t s_reg;
  route_state_t s_next;
  logic assert_any;

  always_comb begin
    s_next = s_reg;
    s_next.p2_act = ev.p2_en & (|p2_req);
    s_next.p3_act = ev.p3_en & (|p3_req);
    s_next.p2_fwd = ev.p2_en ? '0 : p2_req;
    s_next.p3_fwd = ev.p3_en ? '0 : p3_req;
    assert_any = s_next.p2_act | s_next.p3_act;
    // Pin drive lands in the same cycle as the status bits
    if (ev.alt_fn) begin
      s_next.pin_o = ev.invert ? assert_any : ~assert_any;
      s_next.pin_oe = 1'b1;
    end else begin
      s_next.pin_o = gpio_o;
      s_next.pin_oe = gpio_oe;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      // Pin is released in reset; the board pull-up gives its idle level
      s_reg.pin_o <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign ev.p2_act = s_reg.p2_act;
  assign ev.p3_act = s_reg.p3_act;
  assign p2_fwd = s_reg.p2_fwd;
  assign p3_fwd = s_reg.p3_fwd;
  assign pin_o = s_reg.pin_o;
  assign pin_oe = s_reg.pin_oe;

  property p_pin_polarity;
    @(posedge aclk) disable iff (!aresetn)
    $past(ev.alt_fn) |-> pin_o == ($past(ev.invert) ~^ (s_reg.p2_act |
      s_reg.p3_act));
  endproperty
  a_pin_polarity: assert property (p_pin_polarity)
    else $error("event pin polarity wrong");

  property p_p2_suppress;
    @(posedge aclk) disable iff (!aresetn)
    ev.p2_en && (|p2_req) |=> p2_fwd == '0 && s_reg.p2_act;
  endproperty
  a_p2_suppress: assert property (p_p2_suppress)
    else $error("port 2 notification not diverted");

  property p_p3_suppress;
    @(posedge aclk) disable iff (!aresetn)
    ev.p3_en && (|p3_req) |=> p3_fwd == '0 && s_reg.p3_act;
  endproperty
  a_p3_suppress: assert property (p_p3_suppress)
    else $error("port 3 notification not diverted");

  property p_alt_only;
    @(posedge aclk) disable iff (!aresetn)
    !ev.alt_fn |=> pin_oe == $past(gpio_oe) && pin_o == $past(gpio_o);
  endproperty
  a_alt_only: assert property (p_alt_only)
    else $error("pin driven by events outside alternate function");

  property p_never_without_enable;
    @(posedge aclk) disable iff (!aresetn)
    !ev.p2_en ##0 !ev.p3_en |=> !s_reg.p2_act && !s_reg.p3_act;
  endproperty
  a_never_without_enable: assert property (p_never_without_enable)
    else $error("status set while enable clear");

  property p_combine;
    @(posedge aclk) disable iff (!aresetn)
    $past(ev.alt_fn) && (s_reg.p2_act || s_reg.p3_act) |->
      pin_o == $past(ev.invert);
  endproperty
  a_combine: assert property (p_combine)
    else $error("shared pin not asserted for active port");
endmodule

// *** hw/gpe_top.sv ***
// Event diversion block with AXI4-Lite registers
`timescale 1ns/10ps
module gpe_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [gpe_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [gpe_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic [gpe_pkg::REQ_W-1:0] port2_hp_req,
  input wire logic [gpe_pkg::REQ_W-1:0] port3_hp_req,
  output logic [gpe_pkg::REQ_W-1:0] port2_hp_fwd,
  output logic [gpe_pkg::REQ_W-1:0] port3_hp_fwd,
  input wire logic gpio7_gpio_o,
  input wire logic gpio7_gpio_oe,
  input wire logic gpio7_i,
  output logic gpio7_o,
  output logic gpio7_oe,
  output logic irq
);
  typedef struct packed {
    logic invert;
    logic p2_en;
    logic p3_en;
    logic alt_fn;
    logic [1:0] irq_mask;
    logic [1:0] irq_sts;
    logic [1:0] act_prev;
    logic [2:0] pin_sync;
    logic pin_level;
    logic aw_full;
    logic [gpe_pkg::ADDR_W-1:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rd_sts;
  } top_state_t;

  top_state_t s_reg;
  top_state_t s_next;
  gpe_if ev ();

  logic [1:0] act_now;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  logic [31:0] ctrl_word;
  logic [31:0] sts_word;
  logic [31:0] pin_word;
  logic [31:0] isr_word;
  logic [31:0] imr_word;
  logic [31:0] rd_word;
  logic rd_hit;
  logic do_write;

  assign ev.invert = s_reg.invert;
  assign ev.p2_en = s_reg.p2_en;
  assign ev.p3_en = s_reg.p3_en;
  assign ev.alt_fn = s_reg.alt_fn;

  gpe_route u_route (
    .aclk(aclk),
    .aresetn(aresetn),
    .ev(ev.route),
    .p2_req(port2_hp_req),
    .p3_req(port3_hp_req),
    .p2_fwd(port2_hp_fwd),
    .p3_fwd(port3_hp_fwd),
    .gpio_o(gpio7_gpio_o),
    .gpio_oe(gpio7_gpio_oe),
    .pin_o(gpio7_o),
    .pin_oe(gpio7_oe)
  );

  assign act_now = {ev.p3_act, ev.p2_act};

  always_comb begin
    ctrl_word = '0;
    ctrl_word[gpe_pkg::INV_BIT] = s_reg.invert;
    ctrl_word[gpe_pkg::P2_EN_BIT] = s_reg.p2_en;
    ctrl_word[gpe_pkg::P3_EN_BIT] = s_reg.p3_en;
    sts_word = '0;
    sts_word[gpe_pkg::P2_ACT_BIT] = ev.p2_act;
    sts_word[gpe_pkg::P3_ACT_BIT] = ev.p3_act;
    pin_word = '0;
    pin_word[gpe_pkg::ALT_BIT] = s_reg.alt_fn;
    pin_word[gpe_pkg::PIN_LVL_BIT] = s_reg.pin_level;
    isr_word = '0;
    isr_word[gpe_pkg::P2_ACT_BIT] = s_reg.irq_sts[0];
    isr_word[gpe_pkg::P3_ACT_BIT] = s_reg.irq_sts[1];
    imr_word = '0;
    imr_word[gpe_pkg::P2_ACT_BIT] = s_reg.irq_mask[0];
    imr_word[gpe_pkg::P3_ACT_BIT] = s_reg.irq_mask[1];
  end

  always_comb begin
    rd_hit = 1'b1;
    case ({araddr[gpe_pkg::ADDR_W-1:2], 2'h0})
      gpe_pkg::CTRL_OFFS: rd_word = ctrl_word;
      gpe_pkg::STS_OFFS: rd_word = sts_word;
      gpe_pkg::PIN_OFFS: rd_word = pin_word;
      gpe_pkg::IRQ_STS_OFFS: rd_word = isr_word;
      gpe_pkg::IRQ_MASK_OFFS: rd_word = imr_word;
      default: begin
        rd_word = '0;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign awready = !s_reg.aw_full && !s_reg.bvalid;
  assign wready = !s_reg.w_full && !s_reg.bvalid;
  assign arready = !s_reg.rvalid;
  assign do_write = s_reg.aw_full && s_reg.w_full && !s_reg.bvalid;

  always_comb begin
    s_next = s_reg;
    irq_clr = '0;
    // Pin level: three stages, a change counts once the last two agree
    s_next.pin_sync = {s_reg.pin_sync[1:0], gpio7_i};
    if (s_reg.pin_sync[1] == s_reg.pin_sync[2]) begin
      s_next.pin_level = s_reg.pin_sync[2];
    end
    if (awvalid && awready) begin
      s_next.aw_full = 1'b1;
      s_next.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      s_next.w_full = 1'b1;
      s_next.w_data = wdata;
      s_next.w_strb = wstrb;
    end
    if (do_write) begin
      s_next.aw_full = 1'b0;
      s_next.w_full = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = gpe_pkg::RESP_OKAY;
      case ({s_reg.aw_addr[gpe_pkg::ADDR_W-1:2], 2'h0})
        gpe_pkg::CTRL_OFFS: begin
          if (s_reg.w_strb[0]) begin
            s_next.invert = s_reg.w_data[gpe_pkg::INV_BIT];
            s_next.p2_en = s_reg.w_data[gpe_pkg::P2_EN_BIT];
            s_next.p3_en = s_reg.w_data[gpe_pkg::P3_EN_BIT];
          end
        end
        // Status is read-only; writes are accepted and dropped
        gpe_pkg::STS_OFFS: begin
        end
        gpe_pkg::PIN_OFFS: begin
          if (s_reg.w_strb[0]) begin
            s_next.alt_fn = s_reg.w_data[gpe_pkg::ALT_BIT];
          end
        end
        gpe_pkg::IRQ_STS_OFFS: begin
          if (s_reg.w_strb[0]) begin
            irq_clr = {s_reg.w_data[gpe_pkg::P3_ACT_BIT],
              s_reg.w_data[gpe_pkg::P2_ACT_BIT]};
          end
        end
        gpe_pkg::IRQ_MASK_OFFS: begin
          if (s_reg.w_strb[0]) begin
            s_next.irq_mask = {s_reg.w_data[gpe_pkg::P3_ACT_BIT],
              s_reg.w_data[gpe_pkg::P2_ACT_BIT]};
          end
        end
        default: s_next.bresp = gpe_pkg::RESP_SLVERR;
      endcase
    end else if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
    end
    if (arvalid && arready) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = rd_word;
      s_next.rresp = rd_hit ? gpe_pkg::RESP_OKAY : gpe_pkg::RESP_SLVERR;
      s_next.rd_sts = ({araddr[gpe_pkg::ADDR_W-1:2], 2'h0} ==
        gpe_pkg::STS_OFFS);
    end else if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
    end
    // A port's active status bit rising is the interrupt event, whether or not alt_fn routes it to the pin
    s_next.act_prev = act_now;
    irq_set = act_now & ~s_reg.act_prev;
    // Set wins so an event in the clearing cycle is kept
    s_next.irq_sts = (s_reg.irq_sts & ~irq_clr) | irq_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.invert <= gpe_pkg::CTRL_RESET[gpe_pkg::INV_BIT];
      s_reg.p2_en <= gpe_pkg::CTRL_RESET[gpe_pkg::P2_EN_BIT];
      s_reg.p3_en <= gpe_pkg::CTRL_RESET[gpe_pkg::P3_EN_BIT];
      s_reg.alt_fn <= gpe_pkg::PIN_RESET[gpe_pkg::ALT_BIT];
      s_reg.irq_mask <= {gpe_pkg::IRQ_MASK_RESET[gpe_pkg::P3_ACT_BIT],
        gpe_pkg::IRQ_MASK_RESET[gpe_pkg::P2_ACT_BIT]};
      s_reg.irq_sts <= {gpe_pkg::IRQ_STS_RESET[gpe_pkg::P3_ACT_BIT],
        gpe_pkg::IRQ_STS_RESET[gpe_pkg::P2_ACT_BIT]};
    end else begin
      s_reg <= s_next;
    end
  end

  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign rvalid = s_reg.rvalid;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;
  assign irq = |(s_reg.irq_sts & s_reg.irq_mask);

  property p_sts_read_p2;
    @(posedge aclk) disable iff (!aresetn)
    arvalid && arready && ({araddr[gpe_pkg::ADDR_W-1:2], 2'h0} ==
      gpe_pkg::STS_OFFS) |=> rvalid &&
      rdata[gpe_pkg::P2_ACT_BIT] == $past(ev.p2_act) && s_reg.rd_sts;
  endproperty
  a_sts_read_p2: assert property (p_sts_read_p2)
    else $error("port 2 status readback wrong");

  property p_sts_read_p3;
    @(posedge aclk) disable iff (!aresetn)
    arvalid && arready && ({araddr[gpe_pkg::ADDR_W-1:2], 2'h0} ==
      gpe_pkg::STS_OFFS) |=> rvalid &&
      rdata[gpe_pkg::P3_ACT_BIT] == $past(ev.p3_act);
  endproperty
  a_sts_read_p3: assert property (p_sts_read_p3)
    else $error("port 3 status readback wrong");

  property p_sts_needs_enable;
    @(posedge aclk) disable iff (!aresetn)
    s_reg.rvalid && s_reg.rd_sts && $rose(s_reg.rvalid) &&
      !$past(s_reg.p2_en, 2) |-> !rdata[gpe_pkg::P2_ACT_BIT];
  endproperty
  a_sts_needs_enable: assert property (p_sts_needs_enable)
    else $error("port 2 status read set while disabled");

  property p_irq_event;
    @(posedge aclk) disable iff (!aresetn)
    $rose(ev.p2_act) |=> s_reg.irq_sts[0] ##0
      (irq == s_reg.irq_mask[0] || s_reg.irq_mask[1]);
  endproperty
  a_irq_event: assert property (p_irq_event)
    else $error("port 2 event not latched for interrupt");

  property p_sts_needs_enable_p3;
    @(posedge aclk) disable iff (!aresetn)
    s_reg.rd_sts && $rose(s_reg.rvalid) && !$past(s_reg.p3_en, 2) |->
      !rdata[gpe_pkg::P3_ACT_BIT];
  endproperty
  a_sts_needs_enable_p3: assert property (p_sts_needs_enable_p3)
    else $error("port 3 status read set while disabled");

  property p_irq_event_p3;
    @(posedge aclk) disable iff (!aresetn)
    $rose(ev.p3_act) |=> s_reg.irq_sts[1] ##0
      (irq || !s_reg.irq_mask[1]);
  endproperty
  a_irq_event_p3: assert property (p_irq_event_p3)
    else $error("port 3 event not latched for interrupt");

  // A clear in the same cycle as an event must not lose the event
  property p_irq_set_wins;
    @(posedge aclk) disable iff (!aresetn)
    irq_set != 2'h0 |=> (s_reg.irq_sts & $past(irq_set)) == $past(irq_set);
  endproperty
  a_irq_set_wins: assert property (p_irq_set_wins)
    else $error("interrupt event lost");

  property p_write_answer;
    @(posedge aclk) disable iff (!aresetn)
    awvalid && awready && wvalid && wready |-> ##2 bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write response late");

  property p_read_answer;
    @(posedge aclk) disable iff (!aresetn)
    arvalid && arready |=> rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read response late");
endmodule

// *** verif/gpe_sink.sv ***
// System logic model that watches the shared event pin
`timescale 1ns/10ps
module gpe_sink (
  input wire logic pin_o,
  input wire logic pin_oe,
  input wire logic active_high,
  output logic pin_lvl,
  output logic event_seen
);
  // Board pull-up holds the line high whenever the switch lets go of it
  assign pin_lvl = pin_oe ? pin_o : 1'b1;
  assign event_seen = (pin_lvl == active_high);
endmodule

// *** verif/general_purpose_event_signalling_tb_top.sv ***
// Self-checking bench for the event diversion block
`timescale 1ns/10ps
module general_purpose_event_signalling_tb_top;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
  logic gpio7_gpio_o = 0, gpio7_gpio_oe = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, lrd, c = 0, p = 0;
  logic [2:0] port2_hp_req = 0, port3_hp_req = 0, fwd2, fwd3;
  logic awready, wready, bvalid, arready, rvalid, irq, pin_o, pin_oe;
  logic pin_lvl, seen, a2, a3, eo, eoe;
  logic [1:0] bresp, rresp, lresp;
  logic [3:0] wstrb = 4'hf;
  logic [11:0] rst_a [4] = '{gpe_pkg::CTRL_OFFS, gpe_pkg::STS_OFFS,
    gpe_pkg::IRQ_STS_OFFS, gpe_pkg::IRQ_MASK_OFFS};
  int miscompares = 0, num_checks = 0, i;
  integer seed = 32'hfbe6ffac;

  always #20 aclk = ~aclk;

  // Prot and response readies are held constant
  gpe_top gpe_top_inst (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(1'b1), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(1'b1),
    .rdata(rdata), .rresp(rresp), .port2_hp_req(port2_hp_req),
    .port3_hp_req(port3_hp_req), .port2_hp_fwd(fwd2),
    .port3_hp_fwd(fwd3), .gpio7_gpio_o(gpio7_gpio_o),
    .gpio7_gpio_oe(gpio7_gpio_oe), .gpio7_i(pin_lvl), .gpio7_o(pin_o),
    .gpio7_oe(pin_oe), .irq(irq));

  gpe_sink gpe_sink_inst (.pin_o(pin_o), .pin_oe(pin_oe),
    .active_high(c[0]), .pin_lvl(pin_lvl), .event_seen(seen));

  task automatic chk(input string nm, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Handshakes are judged just before the edge, acted on right after it
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bh = 1'b0;
    while (!bh) begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      lresp = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end
  endtask

  task automatic rd(input logic [11:0] a);
    logic ah, rh;
    araddr <= a;
    arvalid <= 1'b1;
    rh = 1'b0;
    while (!rh) begin
      @(negedge aclk);
      ah = arvalid && arready;
      rh = rvalid;
      lrd = rdata;
      lresp = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
    end
  endtask

  task automatic chk_irq(input logic e);
    @(negedge aclk);
    chk("irq", 32'(irq), 32'(e));
    @(posedge aclk);
  endtask

  task automatic give_verdict;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    give_verdict;
  end

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    @(negedge aclk);
    chk("oe_rst", 32'(pin_oe), 32'h0);
    @(posedge aclk);
    for (i = 0; i < 4; i++) begin
      rd(rst_a[i]);
      chk("reg_rst", lrd, 32'h0);
    end
    wr(12'h400, 32'hffffffff);
    chk("wr_err", 32'(lresp), 32'(gpe_pkg::RESP_SLVERR));
    rd(12'h400);
    chk("rd_err", 32'(lresp), 32'(gpe_pkg::RESP_SLVERR));
    // Byte 0 strobe low must leave every control field alone
    wstrb <= 4'he;
    wr(gpe_pkg::CTRL_OFFS, 32'hd);
    wstrb <= 4'hf;
    chk("bresp", 32'(lresp), 32'(gpe_pkg::RESP_OKAY));
    rd(gpe_pkg::CTRL_OFFS);
    chk("strb_ctl", lrd, 32'h0);
    for (i = 0; i < 40; i++) begin
      c = $random(seed);
      p = $random(seed);
      // First rounds walk INTx, MSI and PME alone on each port setting
      if (i < 6) begin
        c[6:4] = 3'h1 << (i % 3);
        c[9:7] = 3'h1 << (i % 3);
        c[3:0] = (i < 3) ? 4'h5 : 4'h8;
        p[0] = 1'b1;
      end
      wr(gpe_pkg::CTRL_OFFS, c);
      wr(gpe_pkg::PIN_OFFS, p);
      wr(gpe_pkg::STS_OFFS, ~c);
      port2_hp_req <= c[6:4];
      port3_hp_req <= c[9:7];
      gpio7_gpio_o <= c[10];
      gpio7_gpio_oe <= c[11];
      a2 = c[2] & (|c[6:4]);
      a3 = c[3] & (|c[9:7]);
      eo = p[0] ? ~((a2 | a3) ^ c[0]) : c[10];
      eoe = p[0] | c[11];
      // Long enough for the three-stage pin synchroniser to settle
      repeat (5) @(posedge aclk);
      @(negedge aclk);
      chk("fwd2", 32'(fwd2), 32'(c[2] ? 3'h0 : c[6:4]));
      chk("fwd3", 32'(fwd3), 32'(c[3] ? 3'h0 : c[9:7]));
      chk("pin_o", 32'(pin_o), 32'(eo));
      chk("pin_oe", 32'(pin_oe), 32'(eoe));
      if (p[0]) chk("seen", 32'(seen), 32'(a2 | a3));
      @(posedge aclk);
      rd(gpe_pkg::STS_OFFS);
      chk("status", lrd, {29'h0, a3, a2, 1'b0});
      rd(gpe_pkg::CTRL_OFFS);
      chk("control", lrd, c & 32'hd);
      rd(gpe_pkg::PIN_OFFS);
      chk("pin_reg", lrd, {30'h0, eoe ? eo : 1'b1, p[0]});
    end
    port2_hp_req <= 3'h0;
    port3_hp_req <= 3'h0;
    wr(gpe_pkg::CTRL_OFFS, 32'h4);
    wr(gpe_pkg::IRQ_STS_OFFS, 32'h6);
    wr(gpe_pkg::IRQ_MASK_OFFS, 32'h6);
    chk_irq(1'b0);
    port2_hp_req <= 3'h2;
    repeat (3) @(posedge aclk);
    chk_irq(1'b1);
    rd(gpe_pkg::IRQ_STS_OFFS);
    chk("irq_sts", lrd, 32'h2);
    wr(gpe_pkg::IRQ_MASK_OFFS, 32'h0);
    chk_irq(1'b0);
    port2_hp_req <= 3'h0;
    wr(gpe_pkg::IRQ_MASK_OFFS, 32'h6);
    wr(gpe_pkg::IRQ_STS_OFFS, 32'h2);
    chk_irq(1'b0);
    rd(gpe_pkg::IRQ_STS_OFFS);
    chk("irq_clr", lrd, 32'h0);
    // Port 3 alone raises its own interrupt status bit
    wr(gpe_pkg::CTRL_OFFS, 32'h8);
    port3_hp_req <= 3'h4;
    repeat (3) @(posedge aclk);
    chk_irq(1'b1);
    rd(gpe_pkg::IRQ_STS_OFFS);
    chk("irq_sts3", lrd, 32'h4);
    give_verdict;
  end
endmodule
